/* File: core/phid_params.svh */
// constants for the parallel host interface detector
`ifndef PHID_PARAMS_SVH
`define PHID_PARAMS_SVH
`define PHID_ADDR_W 6
`define PHID_DATA_W 8
`define PHID_SYNC_STAGES 3
`define PHID_SETTLE_NS 100
`define PHID_CLK_NS 25
`define PHID_SETTLE_CYC ((`PHID_SETTLE_NS + `PHID_CLK_NS - 1) / `PHID_CLK_NS)
`define PHID_ADDR_LSB 0
`endif

/* File: core/phid_pkg.sv */
// types for the parallel host interface detector
package phid_pkg;
  typedef enum logic [2:0] {
    PHID_SEP_DED,
    PHID_SEP_MUX,
    PHID_COM_DED,
    PHID_COM_MUX,
    PHID_EPP,
    PHID_NONE
  } phid_style_t;
endpackage

/* File: core/phid_sync.sv */
// three-stage synchroniser for the host bus pins
module phid_sync #(
  parameter int WIDTH = 15
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] pins_in,
  phid_sync_if.src sync
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, stable_reg;
  logic [WIDTH-1:0] stable_next;
  // the bit map onto the interface is fixed
  if (WIDTH != 15) begin
    $error("phid_sync: width must be 15");
  end
  // a bit only moves once the second and third stages agree
  always_comb begin
    stable_next = stable_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
      end
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      stable_reg <= '1;
    end else if (clk_en_in) begin
      s1_reg <= pins_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end
  assign sync.ale = stable_reg[14];
  assign sync.a2 = stable_reg[13];
  assign sync.a1 = stable_reg[12];
  assign sync.a0 = stable_reg[11];
  assign sync.rd_n = stable_reg[10];
  assign sync.wr_n = stable_reg[9];
  assign sync.cs_n = stable_reg[8];
  assign sync.data = stable_reg[7:0];
endmodule

/* File: core/phid_sync_if.sv */
// synchronised pin levels passed from the synchroniser to the detector
interface phid_sync_if;
  logic ale;
  logic a2;
  logic a1;
  logic a0;
  logic rd_n;
  logic wr_n;
  logic cs_n;
  logic [7:0] data;
  modport src (output ale, a2, a1, a0, rd_n, wr_n, cs_n, data);
  modport dst (input ale, a2, a1, a0, rd_n, wr_n, cs_n, data);
endinterface

/* File: core/phid_top.sv */
// parallel host interface style detector and address latch
//
// Overview of operation
// - dedicated address: latch pin high, strobes decoded
// - muxed: A2 low, A1 high, A0 picks strobes
// - handshake: A2,A1 high, cs low, A0 waits
// - chip select may gate handshake data strobe
// - wait output released after every reset
// - wait driven after first address strobe fall
// - reset clears mode, redoes detection
// - wait low starts, high ends access
// - latch six-bit address from AD0..AD5 in muxed and handshake styles; dedicated style takes A2..A0
`include "phid_params.svh"
module phid_top #(
  parameter int SETTLE_CYC = `PHID_SETTLE_CYC,
  parameter int ACCESS_CYC = 4
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic ale_pin_in,
  input wire logic a2_in,
  input wire logic a1_in,
  input wire logic a0_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic chip_select_n_in,
  input wire logic [7:0] muxed_addr_data_bus_in,
  input wire logic cs_gate_en_in,
  output logic handshake_wait_n_out,
  output logic handshake_wait_oe_n_out,
  output logic [2:0] style_out,
  output logic style_valid_out,
  output logic [5:0] addr_out,
  output logic access_rd_out,
  output logic access_wr_out
);
  phid_sync_if sif ();
  logic [14:0] pins;
  assign pins = {ale_pin_in, a2_in, a1_in, a0_in, read_strobe_n_in,
                 write_strobe_n_in, chip_select_n_in, muxed_addr_data_bus_in};
  phid_sync #(.WIDTH(15)) u_sync (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in),
    .pins_in(pins),
    .sync(sif.src)
  );
  // pins reach sif one edge after the third stage agrees
  localparam int SYNC_LAT = `PHID_SYNC_STAGES + 1;
  // counters are eight bits wide
  if (SETTLE_CYC < 1 || SETTLE_CYC > 256 - SYNC_LAT) begin
    $error("bad SETTLE_CYC");
  end
  if (ACCESS_CYC < 1 || ACCESS_CYC > 255) begin
    $error("bad ACCESS_CYC");
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic phid_pkg::phid_style_t decode_style(
    input logic ale, input logic a2, input logic a1, input logic a0,
    input logic cs_n);
    phid_pkg::phid_style_t s;
    s = phid_pkg::PHID_SEP_DED;
    // handshake straps
    // idle address strobe of the handshake bus stands high
    // limitation: same straps on a dedicated bus read as handshake
    if (a2 && a1 && !cs_n && ale) begin
      s = phid_pkg::PHID_EPP;
    end else if (!a2 && a1 && !ale) begin
      s = a0 ? phid_pkg::PHID_SEP_MUX : phid_pkg::PHID_COM_MUX;
    end else if (ale) begin
      // dedicated style; strobe kind fixed by init routine
      s = phid_pkg::PHID_SEP_DED;
    end
    return s;
  endfunction
  // muxed address strobe is active high except in handshake style
  function automatic logic latch_active(
    input phid_pkg::phid_style_t s, input logic ale);
    return (s == phid_pkg::PHID_EPP) ? !ale : ale;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_SETTLE, ST_RUN} phid_state_t;
  phid_state_t state_reg, state_next;
  phid_pkg::phid_style_t style_reg, style_next;
  logic [7:0] cnt_reg, cnt_next;
  logic valid_reg, valid_next;
  logic [5:0] addr_reg, addr_next;
  logic drive_reg, drive_next;
  logic wait_reg, wait_next;
  logic ale_q_reg, ale_q_next;
  logic strb_q_reg, strb_q_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic [7:0] acc_reg, acc_next;
  logic data_strobe, strobe_act;
  // chip select gating of data strobe
  assign data_strobe = !sif.rd_n && !(cs_gate_en_in && sif.cs_n);
  assign strobe_act = (style_reg == phid_pkg::PHID_EPP) ? data_strobe
                      : (!sif.rd_n || !sif.wr_n) && !sif.cs_n;
  always_comb begin
    state_next = state_reg;
    style_next = style_reg;
    cnt_next = cnt_reg;
    valid_next = valid_reg;
    addr_next = addr_reg;
    drive_next = drive_reg;
    wait_next = wait_reg;
    ale_q_next = sif.ale;
    strb_q_next = strobe_act;
    rd_next = 1'b0;
    wr_next = 1'b0;
    acc_next = acc_reg;
    case (state_reg)
      ST_SETTLE: begin
        // detect from pin levels after reset
        // wait for the straps and the synchroniser both
        if (cnt_reg >= 8'(SETTLE_CYC + SYNC_LAT - 1)) begin
          style_next = decode_style(sif.ale, sif.a2, sif.a1, sif.a0,
                                    sif.cs_n);
          valid_next = 1'b1;
          state_next = ST_RUN;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      ST_RUN: begin
        if (style_reg == phid_pkg::PHID_SEP_MUX ||
            style_reg == phid_pkg::PHID_COM_MUX ||
            style_reg == phid_pkg::PHID_EPP) begin
          if (latch_active(style_reg, sif.ale)) begin
            addr_next = sif.data[5:0];
          end
        end else begin
          addr_next = {3'h0, sif.a2, sif.a1, sif.a0};
        end
        // drive wait after first strobe fall
        if (style_reg == phid_pkg::PHID_EPP && ale_q_reg && !sif.ale) begin
          drive_next = 1'b1;
        end
        // wait low on access, high at end
        if (strobe_act && !strb_q_reg) begin
          wait_next = 1'b0;
          acc_next = 8'h00;
          rd_next = (style_reg == phid_pkg::PHID_SEP_DED ||
                     style_reg == phid_pkg::PHID_SEP_MUX) ? !sif.rd_n
                    : (style_reg == phid_pkg::PHID_EPP) ? sif.wr_n
                    : sif.wr_n;
          wr_next = !rd_next;
        end else if (!wait_reg) begin
          if (acc_reg >= 8'(ACCESS_CYC - 1)) begin
            wait_next = 1'b1;
          end else begin
            acc_next = acc_reg + 8'h01;
          end
        end
      end
      default: begin
        state_next = ST_SETTLE;
      end
    endcase
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ST_SETTLE;
      style_reg <= phid_pkg::PHID_NONE;
      cnt_reg <= 8'h00;
      valid_reg <= 1'b0;
      addr_reg <= 6'h00;
      drive_reg <= 1'b0;
      wait_reg <= 1'b1;
      ale_q_reg <= 1'b1;
      strb_q_reg <= 1'b0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      acc_reg <= 8'h00;
      handshake_wait_n_out <= 1'b1;
      handshake_wait_oe_n_out <= 1'b1;
      style_out <= 3'h5;
      style_valid_out <= 1'b0;
      addr_out <= 6'h00;
      access_rd_out <= 1'b0;
      access_wr_out <= 1'b0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      style_reg <= style_next;
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
      addr_reg <= addr_next;
      drive_reg <= drive_next;
      wait_reg <= wait_next;
      ale_q_reg <= ale_q_next;
      strb_q_reg <= strb_q_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      acc_reg <= acc_next;
      handshake_wait_n_out <= wait_next;
      handshake_wait_oe_n_out <= !drive_next;
      style_out <= style_next;
      style_valid_out <= valid_next;
      addr_out <= addr_next;
      access_rd_out <= rd_next;
      access_wr_out <= wr_next;
    end
  end
endmodule

/* File: verif/phid_host_model.sv */
// handshake-style host partner driving the strapped pins
module phid_host_model (
  input wire logic mclk_in,
  output logic ale_out,
  output logic a2_out,
  output logic a1_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic cs_n_out,
  output logic [7:0] bus_out
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////
  // straps: A2,A1 high, select grounded
  initial begin
    {ale_out, a2_out, a1_out, rd_n_out, wr_n_out, cs_n_out} = 6'h3C;
    bus_out = 8'h00;
  end
  // address phase only written, never read back
  task addr_cyc(input logic [7:0] a);
    @(negedge mclk_in);
    bus_out = a;
    ale_out = 1'b0;
    repeat (6) @(negedge mclk_in);
    ale_out = 1'b1;
    bus_out = ~a;
    repeat (9) @(negedge mclk_in);
  endtask
  // released bus shows the inverse, never a stale value
  task data_cyc(input logic wr, input logic [7:0] d);
    @(negedge mclk_in);
    wr_n_out = ~wr;
    bus_out = d;
    rd_n_out = 1'b0;
    repeat (10) @(negedge mclk_in);
    rd_n_out = 1'b1;
    bus_out = ~d;
    repeat (9) @(negedge mclk_in);
  endtask
endmodule

/* File: verif/phid_top_checker.sv */
// assertions on the detector's ports
module phid_top_checker (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic ale_pin_in,
  input wire logic handshake_wait_n_out,
  input wire logic handshake_wait_oe_n_out,
  input wire logic [2:0] style_out,
  input wire logic style_valid_out,
  input wire logic access_rd_out,
  input wire logic access_wr_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  logic seen_reg;
  logic seen_next;
  always_comb seen_next = seen_reg | ~ale_pin_in;
  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in) seen_reg <= 1'b0;
    else seen_reg <= seen_next;
  sequence strobe_fall;
    $fell(ale_pin_in) ##0 style_out == 3'h4;
  endsequence
  sequence low_burst;
    !handshake_wait_n_out [*4] ##1 handshake_wait_n_out;
  endsequence
  oe_released_a: assert property (!seen_reg |-> handshake_wait_oe_n_out)
    else $error("wait driven before strobe");
  oe_drive_a: assert property (
    strobe_fall |-> ##[1:8] !handshake_wait_oe_n_out)
    else $error("wait not driven");
  oe_stays_a: assert property (
    !handshake_wait_oe_n_out |=> !handshake_wait_oe_n_out)
    else $error("wait released early");
  wait_len_a: assert property (
    $fell(handshake_wait_n_out) |-> low_burst)
    else $error("wait low length");
  wait_pulse_a: assert property (
    $fell(handshake_wait_n_out) |-> access_rd_out || access_wr_out)
    else $error("no access pulse");
  pulse_one_a: assert property (
    access_rd_out || access_wr_out |=> !(access_rd_out || access_wr_out))
    else $error("pulse too long");
  style_hold_a: assert property (
    style_valid_out |=> style_valid_out && $stable(style_out))
    else $error("style changed");
  idle_style_a: assert property (!style_valid_out |-> style_out == 3'h5)
    else $error("style before detection");
  wait_epp_a: assert property (
    !handshake_wait_oe_n_out |-> style_out == 3'h4)
    else $error("wait outside handshake");
endmodule
bind phid_top phid_top_checker chk (.*);

/* File: verif/phid_top_tb.sv */
// testbench for the parallel host interface detector
module phid_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0, arst_n_in = 1'b0, gate = 1'b0;
  logic ale, a2, a1, rd_n, wr_n, cs_n, wait_n, oe_n, valid, acc_rd, acc_wr;
  logic [7:0] bus;
  logic [2:0] style;
  logic [5:0] addr;
  int miscompares = 0, compares = 0, cycles = 0;
  always #12.5 mclk_in = ~mclk_in;
  phid_host_model host (.mclk_in(mclk_in), .ale_out(ale), .a2_out(a2),
    .a1_out(a1), .rd_n_out(rd_n), .wr_n_out(wr_n), .cs_n_out(cs_n),
    .bus_out(bus));
  // a0 pin pulled high while released
  phid_top #(.SETTLE_CYC(4), .ACCESS_CYC(4)) DUT (.mclk_in(mclk_in),
    .arst_n_in(arst_n_in), .clk_en_in(1'b1), .ale_pin_in(ale), .a2_in(a2),
    .a1_in(a1), .a0_in(oe_n ? 1'b1 : wait_n), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .chip_select_n_in(cs_n),
    .muxed_addr_data_bus_in(bus), .cs_gate_en_in(gate),
    .handshake_wait_n_out(wait_n), .handshake_wait_oe_n_out(oe_n),
    .style_out(style), .style_valid_out(valid), .addr_out(addr),
    .access_rd_out(acc_rd), .access_wr_out(acc_wr));
  ////////////////////////////////////////////////////////////////////////
  task chk(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done;
    end
  end
  task t_reset;
    @(negedge mclk_in) arst_n_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (12) @(negedge mclk_in);
    chk("style", 8'h04, {5'h00, style});
    chk("valid", 8'h01, {7'h00, valid});
    chk("oe_n", 8'h01, {7'h00, oe_n});
    $display("reset test done");
  endtask
  task t_addr;
    host.addr_cyc(8'hEA);
    chk("oe_n", 8'h00, {7'h00, oe_n});
    chk("addr", 8'h2A, {2'h0, addr});
    $display("address test done");
  endtask
  // fixed spacing per access keeps the watch window aligned
  task t_access(input logic wr, input logic cs, input int exp_low);
    int n;
    logic rd_s, wr_s;
    n = 0;
    rd_s = 1'b0;
    wr_s = 1'b0;
    @(negedge mclk_in) gate = cs;
    host.cs_n_out = cs;
    fork
      host.data_cyc(wr, 8'h5C);
      repeat (20) @(negedge mclk_in) begin
        n += int'(wait_n === 1'b0);
        rd_s |= acc_rd;
        wr_s |= acc_wr;
      end
    join
    chk("wait_low", 8'(exp_low), 8'(n));
    chk("pulse", {6'h00, wr & ~cs, ~wr & ~cs}, {6'h00, wr_s, rd_s});
    host.cs_n_out = 1'b0;
    gate = 1'b0;
    $display("access test done");
  endtask
  task t_hold;
    @(negedge mclk_in) host.a2_out = 1'b0;
    repeat (10) @(negedge mclk_in);
    chk("style", 8'h04, {5'h00, style});
    host.a2_out = 1'b1;
    $display("hold test done");
  endtask
  // muxed bus with separate strobes; a0 reads high while released
  task t_mux;
    logic rd_s;
    rd_s = 1'b0;
    @(negedge mclk_in) arst_n_in = 1'b0;
    host.a2_out = 1'b0;
    host.ale_out = 1'b0;
    host.wr_n_out = 1'b1;
    repeat (10) @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (12) @(negedge mclk_in);
    chk("style", 8'h01, {5'h00, style});
    host.bus_out = 8'hD3;
    host.ale_out = 1'b1;
    repeat (6) @(negedge mclk_in);
    host.ale_out = 1'b0;
    host.bus_out = 8'h2C;
    repeat (8) @(negedge mclk_in);
    chk("addr", 8'h13, {2'h0, addr});
    host.rd_n_out = 1'b0;
    repeat (10) @(negedge mclk_in) rd_s |= acc_rd;
    host.rd_n_out = 1'b1;
    repeat (9) @(negedge mclk_in);
    chk("pulse", 8'h01, {7'h00, rd_s});
    chk("oe_n", 8'h01, {7'h00, oe_n});
    host.a2_out = 1'b1;
    host.ale_out = 1'b1;
    $display("muxed test done");
  endtask
  initial begin
    t_reset();
    t_addr();
    t_access(1'b1, 1'b0, 4);
    t_access(1'b0, 1'b0, 4);
    t_access(1'b1, 1'b1, 0);
    t_hold();
    t_mux();
    t_reset();
    t_addr();
    test_done();
  end
endmodule
